/* File: dv/tb.sv */
// Self-checking bench for the status/control register pair.
// Assumes the design files are compiled first; the bench drives every input port but hready, which is tied to hreadyout.
`timescale 1ns/1ps
`include "cpu_status_defines.svh"
module tb;
// ----------------------------------------
// Signals and device
// ----------------------------------------
logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata;
logic [1:0]  htrans;
logic [2:0]  hsize, nest_depth_hw;
logic        acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat, loop_run_hw, repeat_run_hw;
logic        nesting_off, prio_top_set, alu_upd, alu_sub, alu_byte;
logic [15:0] alu_a, alu_b, cpu_flags_reg, dummy;
logic        mult_unsigned_sel, loop_early_exit, acc_a_clip_en, acc_b_clip_en;
logic        store_clip_en, super_clip_mode, prog_window_en, rounding_mode_sel;
logic        int_mode_sel, user_irq_blocked;
logic [3:0]  cpu_priority;
int          bad_count;
int          check_count;
logic [33:0] vec [6] = '{{16'h7fff, 16'h0001, 2'b00}, {16'h0005, 16'h0005, 2'b10},
                         {16'h000f, 16'h0001, 2'b01}, {16'h0080, 16'h0080, 2'b01},
                         {16'h0003, 16'h0001, 2'b00}, {16'h0001, 16'h0002, 2'b10}};
cpu_status_core_control u_dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_a_ovf(acc_a_ovf),
    .acc_b_ovf(acc_b_ovf), .acc_a_sat(acc_a_sat), .acc_b_sat(acc_b_sat),
    .loop_run_hw(loop_run_hw), .repeat_run_hw(repeat_run_hw), .nest_depth_hw(nest_depth_hw),
    .nesting_off(nesting_off), .prio_top_set(prio_top_set), .alu_upd(alu_upd),
    .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub), .alu_byte(alu_byte),
    .cpu_flags_reg(cpu_flags_reg), .mult_unsigned_sel(mult_unsigned_sel),
    .loop_early_exit(loop_early_exit), .acc_a_clip_en(acc_a_clip_en),
    .acc_b_clip_en(acc_b_clip_en), .store_clip_en(store_clip_en),
    .super_clip_mode(super_clip_mode), .prog_window_en(prog_window_en),
    .rounding_mode_sel(rounding_mode_sel), .int_mode_sel(int_mode_sel),
    .cpu_priority(cpu_priority), .user_irq_blocked(user_irq_blocked));
always #50 hclk = ~hclk;
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
        bad_count++;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
endtask : check
task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask : final_report
// Entry edge leaves one idle cycle, so no signal gets two values in a step
task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] wd,
                   output logic [15:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[15:0];
endtask : bus
task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus(1'b1, a, d, dummy);
endtask : wr
task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] v;
    bus(1'b0, a, 16'h0000, v);
    check({16'h0, v}, {16'h0, e});
    check(hresp, `RSP_OKAY);
endtask : rd_chk
function automatic logic [4:0] alu_exp(input logic [15:0] a, b, input logic s, y);
    logic [15:0] bb;
    logic [16:0] r;
    logic [8:0]  h;
    logic [4:0]  n;
    bb = s ? ~b : b;
    r  = a + bb + s;
    h  = a[7:0] + bb[7:0] + s;
    n  = a[3:0] + bb[3:0] + s;
    if (y)
        return {n[4], h[7], (a[7] == bb[7]) && (h[7] != a[7]), h[7:0] == 8'h00, h[8]};
    return {h[8], r[15], (a[15] == bb[15]) && (r[15] != a[15]), r[15:0] == 16'h0, r[16]};
endfunction : alu_exp
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_reset();
    rd_chk(`OFS_FLAGS, 16'h0000);
    rd_chk(`OFS_CTRL, 16'h0020);
    @(negedge hclk);
    check({store_clip_en, int_mode_sel, mult_unsigned_sel, prog_window_en}, 4'h8);
endtask : t_reset
task automatic t_ctrl();
    @(posedge hclk);
    nest_depth_hw <= 3'h5;
    wr(`OFS_CTRL, 16'hffff);
    @(negedge hclk);
    check(loop_early_exit, 1'b1);
    check({mult_unsigned_sel, acc_a_clip_en, acc_b_clip_en, store_clip_en, super_clip_mode,
           prog_window_en, rounding_mode_sel, int_mode_sel}, 8'hff);
    @(negedge hclk);
    check(loop_early_exit, 1'b0);
    rd_chk(`OFS_CTRL, 16'h15f7);
    wr(`OFS_CTRL, 16'h0000);
    rd_chk(`OFS_CTRL, 16'h0500);
    wr(12'h008, 16'hffff);
    rd_chk(12'h008, 16'h0000);
    rd_chk(`OFS_CTRL, 16'h0500);
endtask : t_ctrl
task automatic t_status();
    @(posedge hclk);
    clk_en <= 1'b0;
    loop_run_hw <= 1'b1;
    repeat_run_hw <= 1'b1;
    acc_a_ovf <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    check(cpu_flags_reg, 16'h0000);
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check(cpu_flags_reg, 16'h8a10);
    @(posedge hclk);
    acc_a_ovf <= 1'b0;
    acc_b_ovf <= 1'b1;
    acc_b_sat <= 1'b1;
    @(posedge hclk);
    acc_b_sat <= 1'b0;
    loop_run_hw <= 1'b0;
    repeat_run_hw <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check(cpu_flags_reg, 16'h5c00);
    wr(`OFS_FLAGS, 16'hfe00);
    rd_chk(`OFS_FLAGS, 16'h5c00);
    @(posedge hclk);
    acc_b_ovf <= 1'b0;
    wr(`OFS_FLAGS, 16'hf800);
    rd_chk(`OFS_FLAGS, 16'h0000);
    @(posedge hclk);
    acc_a_sat <= 1'b1;
    @(posedge hclk);
    acc_a_sat <= 1'b0;
    rd_chk(`OFS_FLAGS, 16'h2400);
    wr(`OFS_FLAGS, 16'h0400);
    rd_chk(`OFS_FLAGS, 16'h0000);
endtask : t_status
task automatic t_prio();
    wr(`OFS_FLAGS, 16'h00e0);
    @(negedge hclk);
    check({cpu_priority, user_irq_blocked}, 5'h0f);
    wr(`OFS_FLAGS, 16'h00c0);
    @(negedge hclk);
    check({cpu_priority, user_irq_blocked}, 5'h0c);
    @(posedge hclk);
    nesting_off <= 1'b1;
    wr(`OFS_FLAGS, 16'h0020);
    rd_chk(`OFS_FLAGS, 16'h00c0);
    @(posedge hclk);
    nesting_off <= 1'b0;
    prio_top_set <= 1'b1;
    @(posedge hclk);
    prio_top_set <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check({cpu_priority, user_irq_blocked}, 5'h1d);
    rd_chk(`OFS_CTRL, 16'h0508);
    wr(`OFS_CTRL, 16'h0000);
    rd_chk(`OFS_CTRL, 16'h0500);
endtask : t_prio
task automatic t_alu();
    foreach (vec[i])
    begin
        @(posedge hclk);
        {alu_a, alu_b, alu_sub, alu_byte} <= vec[i];
        alu_upd <= 1'b1;
        @(posedge hclk);
        alu_upd <= 1'b0;
        @(negedge hclk);
        check({cpu_flags_reg[8], cpu_flags_reg[3:0]}, alu_exp(vec[i][33:18],
              vec[i][17:2], vec[i][1], vec[i][0]));
    end
endtask : t_alu
initial
begin
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, nest_depth_hw} = '0;
    {acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat, loop_run_hw, repeat_run_hw} = '0;
    {nesting_off, prio_top_set, alu_upd, alu_sub, alu_byte, alu_a, alu_b} = '0;
    clk_en = 1'b1;
    hsize = 3'b010;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_prio();
    t_alu();
    final_report();
end
// Run needs about 110 cycles; cut off far beyond that
initial
begin
    #500000;
    bad_count++;
    final_report();
end
endmodule : tb

/* File: hdl/alu_flag_calc.sv */
// Flag calculator for one add or subtract of the ALU.
// Assumes subtract means a + ~b + 1, so carry reads as no-borrow.
`timescale 1ns/1ps
`include "cpu_status_defines.svh"
module alu_flag_calc (
    flag_event_if.calc fl
);
    logic [15:0] b_eff;
    logic        cin;
    logic [4:0]  s_nib;
    logic [8:0]  s_byte;
    logic [16:0] s_word;
    logic        sgn_a;
    logic        sgn_b;
    logic        sgn_r;

    always_comb
    begin
        b_eff  = fl.op_sub ? ~fl.op_b : fl.op_b;
        cin    = fl.op_sub;
        s_nib  = {1'b0, fl.op_a[`NIB_W-1:0]} + {1'b0, b_eff[`NIB_W-1:0]}
                 + {4'h0, cin};
        s_byte = {1'b0, fl.op_a[`BYTE_W-1:0]} + {1'b0, b_eff[`BYTE_W-1:0]}
                 + {8'h00, cin};
        s_word = {1'b0, fl.op_a} + {1'b0, b_eff} + {16'h0000, cin};
        // Byte ops judge flags on the low byte only
        if (fl.op_byte)
        begin
            sgn_a     = fl.op_a[`BYTE_W-1];
            sgn_b     = b_eff[`BYTE_W-1];
            sgn_r     = s_byte[`BYTE_W-1];
            fl.zero   = (s_byte[`BYTE_W-1:0] == 8'h00);
            fl.carry  = s_byte[`BYTE_W];
            fl.hcarry = s_nib[`NIB_W];
        end
        else
        begin
            sgn_a     = fl.op_a[`WORD_W-1];
            sgn_b     = b_eff[`WORD_W-1];
            sgn_r     = s_word[`WORD_W-1];
            fl.zero   = (s_word[`WORD_W-1:0] == 16'h0000);
            fl.carry  = s_word[`WORD_W];
            fl.hcarry = s_byte[`BYTE_W];
        end
        fl.neg  = sgn_r;
        fl.wrap = (sgn_a == sgn_b) && (sgn_r != sgn_a);
    end
endmodule : alu_flag_calc

/* File: hdl/cpu_status_core_control.sv */
// Status and core-control register pair of the processor core.
// Assumes an AHB-Lite master, execution hardware on the same clock.
`timescale 1ns/1ps
`include "cpu_status_defines.svh"
module cpu_status_core_control (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        clk_en,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic        hresp,
    output logic [31:0] hrdata,
    input  logic        acc_a_ovf,
    input  logic        acc_b_ovf,
    input  logic        acc_a_sat,
    input  logic        acc_b_sat,
    input  logic        loop_run_hw,
    input  logic        repeat_run_hw,
    input  logic [2:0]  nest_depth_hw,
    input  logic        nesting_off,
    input  logic        prio_top_set,
    input  logic        alu_upd,
    input  logic [15:0] alu_a,
    input  logic [15:0] alu_b,
    input  logic        alu_sub,
    input  logic        alu_byte,
    output logic [15:0] cpu_flags_reg,
    output logic        mult_unsigned_sel,
    output logic        loop_early_exit,
    output logic        acc_a_clip_en,
    output logic        acc_b_clip_en,
    output logic        store_clip_en,
    output logic        super_clip_mode,
    output logic        prog_window_en,
    output logic        rounding_mode_sel,
    output logic        int_mode_sel,
    output logic [3:0]  cpu_priority,
    output logic        user_irq_blocked
);
    // ----------------------------------------
    // Word packing
    // ----------------------------------------
    function automatic logic [15:0] pack_flags(cpu_status_pkg::core_st_t s);
        logic [15:0] w;
        w                         = 16'h0000;
        w[`B_AOVF]                = s.acc_a_overflow;
        w[`B_BOVF]                = s.acc_b_overflow;
        w[`B_ACLIP]               = s.acc_a_clip_sticky;
        w[`B_BCLIP]               = s.acc_b_clip_sticky;
        w[`B_ANYOVF]              = s.acc_a_overflow | s.acc_b_overflow;
        w[`B_ANYCLIP]             = s.acc_a_clip_sticky | s.acc_b_clip_sticky;
        w[`B_LOOP]                = s.loop_running;
        w[`B_HCARRY]              = s.half_carry_flag;
        w[`B_PRIO_HI:`B_PRIO_LO]  = s.cpu_priority_low_bits;
        w[`B_REP]                 = s.repeat_running;
        w[`B_NEG]                 = s.neg_flag;
        w[`B_WRAP]                = s.signed_wrap_flag;
        w[`B_ZERO]                = s.zero_flag;
        w[`B_CARRY]               = s.carry_flag;
        return w;
    endfunction : pack_flags

    function automatic logic [15:0] pack_ctrl(cpu_status_pkg::core_st_t s);
        logic [15:0] w;
        w                           = 16'h0000;
        w[`B_MULU]                  = s.mult_unsigned_sel;
        w[`B_EXIT]                  = 1'b0;
        w[`B_DEPTH_HI:`B_DEPTH_LO]  = s.loop_nest_depth;
        w[`B_ACLIPEN]               = s.acc_a_clip_en;
        w[`B_BCLIPEN]               = s.acc_b_clip_en;
        w[`B_STCLIP]                = s.store_clip_en;
        w[`B_SUPER]                 = s.super_clip_mode;
        w[`B_PTOP]                  = s.cpu_priority_top_bit;
        w[`B_PWIN]                  = s.prog_window_en;
        w[`B_ROUND]                 = s.rounding_mode_sel;
        w[`B_IMODE]                 = s.int_mode_sel;
        return w;
    endfunction : pack_ctrl

    // ----------------------------------------
    // Flag calculator
    // ----------------------------------------
    flag_event_if fl ();

    assign fl.op_a    = alu_a;
    assign fl.op_b    = alu_b;
    assign fl.op_sub  = alu_sub;
    assign fl.op_byte = alu_byte;

    alu_flag_calc u_calc (
        .fl (fl.calc)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    cpu_status_pkg::core_st_t s_q;
    cpu_status_pkg::core_st_t s_d;
    logic                     take;
    logic [15:0]              wd;
    logic                     wr_flags;
    logic                     wr_ctrl;

    always_comb
    begin
        s_d      = s_q;
        wd       = hwdata[15:0];
        wr_flags = s_q.dph_wr && s_q.dph_flags;
        wr_ctrl  = s_q.dph_wr && s_q.dph_ctrl;
        s_d.ready = 1'b1;

        // Hardware-owned levels; bus writes never reach these
        s_d.acc_a_overflow  = acc_a_ovf;
        s_d.acc_b_overflow  = acc_b_ovf;
        s_d.loop_running    = loop_run_hw;
        s_d.repeat_running  = repeat_run_hw;
        s_d.loop_nest_depth = nest_depth_hw;

        // Flags word write; a zero in a clip bit clears it
        if (wr_flags)
        begin
            if (!wd[`B_ACLIP] || !wd[`B_ANYCLIP])
            begin
                s_d.acc_a_clip_sticky = 1'b0;
            end
            if (!wd[`B_BCLIP] || !wd[`B_ANYCLIP])
            begin
                s_d.acc_b_clip_sticky = 1'b0;
            end
            s_d.half_carry_flag  = wd[`B_HCARRY];
            s_d.neg_flag         = wd[`B_NEG];
            s_d.signed_wrap_flag = wd[`B_WRAP];
            s_d.zero_flag        = wd[`B_ZERO];
            s_d.carry_flag       = wd[`B_CARRY];
            if (!nesting_off)
            begin
                s_d.cpu_priority_low_bits = wd[`B_PRIO_HI:`B_PRIO_LO];
            end
        end

        // Control word write
        if (wr_ctrl)
        begin
            s_d.mult_unsigned_sel = wd[`B_MULU];
            s_d.acc_a_clip_en     = wd[`B_ACLIPEN];
            s_d.acc_b_clip_en     = wd[`B_BCLIPEN];
            s_d.store_clip_en     = wd[`B_STCLIP];
            s_d.super_clip_mode   = wd[`B_SUPER];
            s_d.prog_window_en    = wd[`B_PWIN];
            s_d.rounding_mode_sel = wd[`B_ROUND];
            s_d.int_mode_sel      = wd[`B_IMODE];
            if (!wd[`B_PTOP])
            begin
                s_d.cpu_priority_top_bit = 1'b0;
            end
        end
        s_d.loop_early_exit = wr_ctrl && wd[`B_EXIT];

        // Hardware sets come after the bus writes so a same-cycle clear loses
        if (acc_a_sat)
        begin
            s_d.acc_a_clip_sticky = 1'b1;
        end
        if (acc_b_sat)
        begin
            s_d.acc_b_clip_sticky = 1'b1;
        end
        if (prio_top_set)
        begin
            s_d.cpu_priority_top_bit = 1'b1;
        end

        // ALU result beats a software write in the same cycle
        if (alu_upd)
        begin
            s_d.neg_flag         = fl.neg;
            s_d.signed_wrap_flag = fl.wrap;
            s_d.zero_flag        = fl.zero;
            s_d.carry_flag       = fl.carry;
            s_d.half_carry_flag  = fl.hcarry;
        end

        s_d.irq_blocked = s_d.cpu_priority_top_bit ||
                          (s_d.cpu_priority_low_bits == `PRIO_MAX);

        // Address phase; read data built from next state so a
        // read right behind a write sees the written value
        take = hsel && hready && htrans[`TRANS_BIT];
        s_d.dph_wr    = take && hwrite;
        s_d.dph_flags = take && (haddr[`ADDR_W-1:0] == `OFS_FLAGS);
        s_d.dph_ctrl  = take && (haddr[`ADDR_W-1:0] == `OFS_CTRL);
        s_d.hrdata    = 32'h0000_0000;
        if (take && !hwrite && s_d.dph_flags)
        begin
            s_d.hrdata = {16'h0000, pack_flags(s_d)};
        end
        if (take && !hwrite && s_d.dph_ctrl)
        begin
            s_d.hrdata = {16'h0000, pack_ctrl(s_d)};
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q               <= '0;
            s_q.store_clip_en <= `STCLIP_RST;
            s_q.ready         <= 1'b1;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Zero wait states; hsize is ignored, only words are mapped
    assign hreadyout         = s_q.ready;
    assign hresp             = `RSP_OKAY;
    assign hrdata            = s_q.hrdata;
    assign cpu_flags_reg     = pack_flags(s_q);
    assign mult_unsigned_sel = s_q.mult_unsigned_sel;
    assign loop_early_exit   = s_q.loop_early_exit;
    assign acc_a_clip_en     = s_q.acc_a_clip_en;
    assign acc_b_clip_en     = s_q.acc_b_clip_en;
    assign store_clip_en     = s_q.store_clip_en;
    assign super_clip_mode   = s_q.super_clip_mode;
    assign prog_window_en    = s_q.prog_window_en;
    assign rounding_mode_sel = s_q.rounding_mode_sel;
    assign int_mode_sel      = s_q.int_mode_sel;
    assign cpu_priority      = {s_q.cpu_priority_top_bit,
                                s_q.cpu_priority_low_bits};
    assign user_irq_blocked  = s_q.irq_blocked;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [15:0] flags_w;
    logic [15:0] ctrl_w;
    assign flags_w = pack_flags(s_q);
    assign ctrl_w  = pack_ctrl(s_q);

    AST_OVF_FOLLOW: assert property (
        clk_en |=> (s_q.acc_a_overflow == $past(acc_a_ovf)) &&
                   (s_q.acc_b_overflow == $past(acc_b_ovf)))
        else $error("overflow flag does not follow accumulator");

    AST_CLIP_SET: assert property (
        clk_en && acc_a_sat |=> s_q.acc_a_clip_sticky)
        else $error("clip sticky flag not set");

    AST_CLIP_NO_SW_SET: assert property (
        clk_en && !acc_b_sat && !s_q.acc_b_clip_sticky
        |=> !s_q.acc_b_clip_sticky)
        else $error("clip sticky flag set without event");

    AST_ANY_OVF: assert property (
        clk_en |=> flags_w[`B_ANYOVF] == ($past(acc_a_ovf) || $past(acc_b_ovf)))
        else $error("combined overflow wrong");

    AST_ANY_CLIP_CLR: assert property (
        clk_en && s_q.dph_wr && s_q.dph_flags && !hwdata[`B_ANYCLIP]
        && !acc_a_sat && !acc_b_sat
        |=> !s_q.acc_a_clip_sticky && !s_q.acc_b_clip_sticky)
        else $error("combined clip clear left a flag set");

    AST_LOOP_MIRROR: assert property (
        clk_en ##1 clk_en |=> s_q.loop_running == $past(loop_run_hw))
        else $error("loop running bit wrong");

    AST_PRIO_BLOCK: assert property (
        user_irq_blocked == (cpu_priority[3] ||
                             (cpu_priority[2:0] == `PRIO_MAX)))
        else $error("user interrupt block wrong");

    AST_PRIO_FROZEN: assert property (
        clk_en && nesting_off |=> $stable(s_q.cpu_priority_low_bits))
        else $error("priority bits changed while nesting off");

    AST_ZERO_FLAG: assert property (
        clk_en && alu_upd |=> s_q.zero_flag == $past(fl.zero))
        else $error("zero flag not updated by ALU");

    AST_EXIT_PULSE: assert property (
        clk_en && s_q.dph_wr && s_q.dph_ctrl && hwdata[`B_EXIT]
        |=> loop_early_exit && (ctrl_w[`B_EXIT] == 1'b0))
        else $error("early exit pulse missing");

    AST_UNUSED_ZERO: assert property (
        ctrl_w[`B_UNUSED_HI:`B_UNUSED_LO] == 3'h0)
        else $error("unused control bits not zero");

    AST_OVF_NO_SW: assert property (
        clk_en && s_q.dph_wr && s_q.dph_flags && (acc_a_ovf == 1'b0)
        |=> !s_q.acc_a_overflow)
        else $error("software changed overflow flag");

    COV_CLIP_SET: cover property (clk_en && acc_a_sat ##1 s_q.acc_a_clip_sticky);
    COV_CLIP_CLR: cover property (clk_en && s_q.dph_wr && s_q.dph_flags
                                  && !hwdata[`B_ANYCLIP]);
    COV_EXIT:     cover property (loop_early_exit);
    COV_READ:     cover property (hsel && hready && htrans[`TRANS_BIT] && !hwrite);
endmodule : cpu_status_core_control

/* File: hdl/cpu_status_defines.svh */
// Bit positions, offsets and reset values of the status/control pair.
// Assumes inclusion by bare name from design files.
`ifndef CPU_STATUS_DEFINES_SVH
`define CPU_STATUS_DEFINES_SVH
// ----------------------------------------
// Bus map
// ----------------------------------------
`define ADDR_W      12
`define OFS_FLAGS   12'h000
`define OFS_CTRL    12'h004
`define TRANS_BIT   1
`define RSP_OKAY    1'b0
// ----------------------------------------
// Flags word
// ----------------------------------------
`define B_AOVF      15
`define B_BOVF      14
`define B_ACLIP     13
`define B_BCLIP     12
`define B_ANYOVF    11
`define B_ANYCLIP   10
`define B_LOOP      9
`define B_HCARRY    8
`define B_PRIO_HI   7
`define B_PRIO_LO   5
`define B_REP       4
`define B_NEG       3
`define B_WRAP      2
`define B_ZERO      1
`define B_CARRY     0
// ----------------------------------------
// Control word
// ----------------------------------------
`define B_MULU      12
`define B_EXIT      11
`define B_DEPTH_HI  10
`define B_DEPTH_LO  8
`define B_ACLIPEN   7
`define B_BCLIPEN   6
`define B_STCLIP    5
`define B_SUPER     4
`define B_PTOP      3
`define B_PWIN      2
`define B_ROUND     1
`define B_IMODE     0
`define B_UNUSED_HI 15
`define B_UNUSED_LO 13
`define STCLIP_RST  1'b1
`define PRIO_MAX    3'h7
// ----------------------------------------
// ALU widths
// ----------------------------------------
`define NIB_W       4
`define BYTE_W      8
`define WORD_W      16
`endif

/* File: hdl/cpu_status_pkg.sv */
// Types of the status/control register pair.
// Assumes nothing beyond a SystemVerilog compiler.
package cpu_status_pkg;
    typedef struct packed {
        logic        dph_wr;
        logic        dph_flags;
        logic        dph_ctrl;
        logic        ready;
        logic [31:0] hrdata;
        logic        acc_a_overflow;
        logic        acc_b_overflow;
        logic        acc_a_clip_sticky;
        logic        acc_b_clip_sticky;
        logic        loop_running;
        logic        half_carry_flag;
        logic [2:0]  cpu_priority_low_bits;
        logic        repeat_running;
        logic        neg_flag;
        logic        signed_wrap_flag;
        logic        zero_flag;
        logic        carry_flag;
        logic        mult_unsigned_sel;
        logic        loop_early_exit;
        logic [2:0]  loop_nest_depth;
        logic        acc_a_clip_en;
        logic        acc_b_clip_en;
        logic        store_clip_en;
        logic        super_clip_mode;
        logic        cpu_priority_top_bit;
        logic        prog_window_en;
        logic        rounding_mode_sel;
        logic        int_mode_sel;
        logic        irq_blocked;
    } core_st_t;
endpackage : cpu_status_pkg

/* File: hdl/flag_event_if.sv */
// Operands in, ALU flags out, between core and flag calculator.
// Assumes both ends on the same clock; purely combinational.
`timescale 1ns/1ps
interface flag_event_if;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic        op_sub;
    logic        op_byte;
    logic        neg;
    logic        wrap;
    logic        zero;
    logic        carry;
    logic        hcarry;
    modport calc (input op_a, op_b, op_sub, op_byte,
                  output neg, wrap, zero, carry, hcarry);
    modport core (output op_a, op_b, op_sub, op_byte,
                  input neg, wrap, zero, carry, hcarry);
endinterface : flag_event_if
